/* tar_pkg.sv */
package tar_pkg;

  // Clock and base timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned QUARTER_MS     = 250;
  localparam int unsigned QUARTER_CYCLES = CLK_HZ / 1000 * QUARTER_MS;
  localparam int unsigned TRIG_DELAY_MS  = 10;
  localparam int unsigned TRIG_CYCLES    = CLK_HZ / 1000 * TRIG_DELAY_MS;

  // Periods counted in quarter seconds
  localparam logic [6:0] AUTH_Q_1S  = 7'h04;
  localparam logic [6:0] AUTH_Q_8S  = 7'h20;
  localparam logic [6:0] AUTH_Q_16S = 7'h40;
  localparam logic [6:0] POLL_Q_025 = 7'h01;
  localparam logic [6:0] POLL_Q_050 = 7'h02;
  localparam logic [6:0] POLL_Q_100 = 7'h04;

  // Shadow memory map
  localparam int unsigned MEM_DEPTH     = 30;
  localparam logic [4:0]  MEM_CHALLENGE_TRIGGER_IN_BASE = 5'h00;
  localparam logic [4:0]  MEM_MAC_BASE  = 5'h08;
  localparam logic [7:0]  MEM_CFG_LO    = 8'h1C;
  localparam logic [7:0]  MEM_CFG_HI    = 8'h1D;
  localparam logic [7:0]  MEM_RESERVED  = 8'hFF;
  localparam logic [7:0]  MEM_RESET     = 8'h00;

  // auth_config_word fields
  localparam int unsigned CFG_RETRY_LSB  = 0;
  localparam int unsigned CFG_PAUTH_LSB  = 2;
  localparam int unsigned CFG_POLL_LSB   = 4;
  localparam int unsigned CFG_ASYNC_BIT  = 6;
  localparam int unsigned CFG_POL_BIT    = 7;
  localparam int unsigned CFG_STYLE_BIT  = 8;
  localparam int unsigned CFG_SPEED_BIT  = 9;
  localparam int unsigned CFG_LOCK_LSB   = 10;
  localparam int unsigned CFG_FAIL_FLAG_BIT  = 13;
  localparam int unsigned CFG_PASS_FLAG_BIT  = 14;
  localparam int unsigned CFG_LOCK_STATUS_FLAG_BIT  = 15;
  localparam logic [1:0]  LOCK_CODE      = 2'h2;

  // Token exchange
  localparam logic [7:0] CMD_SKIP   = 8'hCC;
  localparam logic [4:0] CHALLENGE_TRIGGER_IN_LAST  = 5'h07;
  localparam logic [7:0] MAC_LAST   = 8'h9F;

  typedef enum logic [1:0] {
    TAR_OP_RESET = 2'h0,
    TAR_OP_WRITE = 2'h1,
    TAR_OP_ZERO8 = 2'h2,
    TAR_OP_READ  = 2'h3
  } tar_op_e;

  typedef struct packed {
    tar_op_e    kind;
    logic [7:0] data;
  } tar_mop_s;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_RST  = 10'h002,
    S_SKIP = 10'h004,
    S_WCMD = 10'h008,
    S_CHALLENGE_TRIGGER_IN = 10'h010,
    S_MCMD = 10'h020,
    S_ZERO = 10'h040,
    S_READ = 10'h080,
    S_FRST = 10'h100,
    S_POLL = 10'h200
  } tar_state_e;

endpackage

/* tar_auth_ctrl.sv */
`timescale 1ns/10ps
module tar_auth_ctrl #(
  parameter int unsigned QUARTER_CYCLES = tar_pkg::QUARTER_CYCLES,
  parameter int unsigned TRIG_CYCLES    = tar_pkg::TRIG_CYCLES,
  parameter logic [7:0]  CMD_WRITE_CHALLENGE_TRIGGER_IN = 8'h0F,
  parameter logic [7:0]  CMD_COMPUTE    = 8'h33
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              challenge_trigger_in,
  output tar_pkg::tar_mop_s      mop,
  output logic                   mop_valid,
  output logic                   mop_strong_pullup,
  input  wire logic              mop_done,
  input  wire logic              mop_presence,
  input  wire logic              mop_bit,
  input  wire logic              async_presence_in,
  output logic                   overdrive_sel,
  output logic                   pass_line_out,
  output logic                   pass_line_oe,
  output logic                   fail_line_out,
  output logic                   fail_line_oe,
  input  wire logic              prog_wr_en,
  input  wire logic [7:0]        prog_addr,
  input  wire logic [7:0]        prog_wr_data,
  input  wire logic              prog_copy,
  output logic [7:0]             prog_rd_data
);

  logic [7:0]  mem [tar_pkg::MEM_DEPTH];
  logic [15:0] auth_config_word;
  logic        lock_reg, lock_next;
  logic [7:0]  rd_reg, rd_next;

  tar_pkg::tar_state_e st_reg, st_next;
  logic [3:0]  att_reg, att_next;
  logic [4:0]  byte_reg, byte_next;
  logic [7:0]  bit_reg, bit_next;
  logic        mism_reg, mism_next;
  logic        pass_reg, pass_next, fail_reg, fail_next;
  logic        pass_flag_reg, pass_flag_next, fail_flag_reg, fail_flag_next;
  logic [21:0] qcnt_reg, qcnt_next;
  logic        blink_reg, blink_next;
  logic [6:0]  acnt_reg, acnt_next, pcnt_reg, pcnt_next;
  logic        areq_reg, areq_next, preq_reg, preq_next;
  logic [16:0] dcnt_reg, dcnt_next;
  logic        dpend_reg, dpend_next;
  logic        tprev_reg, tprev_next;
  logic        trig_act, qtick, start, bit_bad;
  logic [6:0]  auth_per, poll_per;

  function automatic logic [3:0] last_attempt(input logic [1:0] sel);
    last_attempt = 4'((5'h01 << sel) - 5'h01);
  endfunction

  function automatic logic [6:0] period_q(input logic [1:0] sel, input logic poll);
    case (sel)
      2'h1:    period_q = poll ? tar_pkg::POLL_Q_025 : tar_pkg::AUTH_Q_1S;
      2'h2:    period_q = poll ? tar_pkg::POLL_Q_050 : tar_pkg::AUTH_Q_8S;
      2'h3:    period_q = poll ? tar_pkg::POLL_Q_100 : tar_pkg::AUTH_Q_16S;
      default: period_q = 7'h00;
    endcase
  endfunction

  // Status bits live outside the shadow so writes can never forge them
  assign auth_config_word = {lock_reg, pass_flag_reg, fail_flag_reg, 1'b0,
                             mem[29][3:0], mem[28]};
  assign overdrive_sel = auth_config_word[tar_pkg::CFG_SPEED_BIT];
  assign auth_per = period_q(auth_config_word[tar_pkg::CFG_PAUTH_LSB +: 2], 1'b0);
  assign poll_per = period_q(auth_config_word[tar_pkg::CFG_POLL_LSB +: 2], 1'b1);
  assign trig_act = challenge_trigger_in
                    ~^ auth_config_word[tar_pkg::CFG_POL_BIT];
  assign bit_bad = mop_bit != mem[tar_pkg::MEM_MAC_BASE + 5'(bit_reg[7:3])][bit_reg[2:0]];

  // Programming port: shadow writes, copy commits the lock
  always_comb begin
    lock_next = lock_reg;
    if (prog_copy && !lock_reg &&
        auth_config_word[tar_pkg::CFG_LOCK_LSB +: 2] == tar_pkg::LOCK_CODE) begin
      lock_next = 1'b1;
    end
    if (prog_addr == tar_pkg::MEM_CFG_HI) begin
      rd_next = auth_config_word[15:8];
    end else if (prog_addr < 8'(tar_pkg::MEM_DEPTH)) begin
      rd_next = mem[prog_addr[4:0]];
    end else begin
      rd_next = tar_pkg::MEM_RESERVED;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= 1'b0;
      rd_reg   <= tar_pkg::MEM_RESET;
      for (int i = 0; i < tar_pkg::MEM_DEPTH; i++) begin
        mem[i] <= tar_pkg::MEM_RESET;
      end
    end else begin
      lock_reg <= lock_next;
      rd_reg   <= rd_next;
      // Locked storage ignores writes; reserved space is not stored
      if (prog_wr_en && !lock_reg && prog_addr < 8'(tar_pkg::MEM_DEPTH)) begin
        mem[prog_addr[4:0]] <= prog_wr_data;
      end
    end
  end

  assign prog_rd_data = rd_reg;

  // Token exchange and status
  assign mop_valid = st_reg != tar_pkg::S_IDLE;
  assign mop_strong_pullup = st_reg == tar_pkg::S_ZERO;
  assign qtick = qcnt_reg == 22'(QUARTER_CYCLES - 1);
  assign start = st_reg == tar_pkg::S_IDLE && !preq_reg &&
                 (areq_reg || (dpend_reg && dcnt_reg == 17'(TRIG_CYCLES - 1)));

  always_comb begin
    mop.kind = tar_pkg::TAR_OP_RESET;
    mop.data = tar_pkg::CMD_SKIP;
    case (st_reg)
      tar_pkg::S_SKIP: mop.kind = tar_pkg::TAR_OP_WRITE;
      tar_pkg::S_WCMD: begin
        mop.kind = tar_pkg::TAR_OP_WRITE;
        mop.data = CMD_WRITE_CHALLENGE_TRIGGER_IN;
      end
      tar_pkg::S_CHALLENGE_TRIGGER_IN: begin
        mop.kind = tar_pkg::TAR_OP_WRITE;
        mop.data = mem[tar_pkg::MEM_CHALLENGE_TRIGGER_IN_BASE + byte_reg];
      end
      tar_pkg::S_MCMD: begin
        mop.kind = tar_pkg::TAR_OP_WRITE;
        mop.data = CMD_COMPUTE;
      end
      tar_pkg::S_ZERO: mop.kind = tar_pkg::TAR_OP_ZERO8;
      tar_pkg::S_READ: mop.kind = tar_pkg::TAR_OP_READ;
      default: ;
    endcase
  end

  always_comb begin
    st_next    = st_reg;
    att_next   = att_reg;
    byte_next  = byte_reg;
    bit_next   = bit_reg;
    mism_next  = mism_reg;
    pass_next  = pass_reg;
    fail_next  = fail_reg;
    pass_flag_next = pass_flag_reg;
    fail_flag_next = fail_flag_reg;
    qcnt_next  = qtick ? 22'h00_0000 : qcnt_reg + 22'h00_0001;
    blink_next = qtick ? !blink_reg : blink_reg;
    acnt_next  = acnt_reg;
    pcnt_next  = pcnt_reg;
    areq_next  = areq_reg;
    preq_next  = preq_reg;
    dcnt_next  = dpend_reg ? dcnt_reg + 17'(dcnt_reg != 17'(TRIG_CYCLES - 1)) : 17'h0_0000;
    dpend_next = dpend_reg;
    tprev_next = trig_act;

    // Quarter-second periods; zero period means off
    if (qtick && auth_per != 7'h00) begin
      acnt_next = acnt_reg + 7'h01;
      if (acnt_reg + 7'h01 >= auth_per) begin
        acnt_next = 7'h00;
        areq_next = 1'b1;
      end
    end
    if (qtick && poll_per != 7'h00) begin
      pcnt_next = pcnt_reg + 7'h01;
      if (pcnt_reg + 7'h01 >= poll_per) begin
        pcnt_next = 7'h00;
        preq_next = 1'b1;
      end
    end

    // Reset leaves tprev low, so an active level at power-up counts as an edge
    if ((trig_act && !tprev_reg) ||
        (async_presence_in && auth_config_word[tar_pkg::CFG_ASYNC_BIT])) begin
      dpend_next = 1'b1;
      dcnt_next  = 17'h0_0000;
    end
    if (!trig_act && tprev_reg) begin
      pass_next  = 1'b0;
      fail_next  = 1'b0;
      pass_flag_next = 1'b0;
      fail_flag_next = 1'b0;
    end

    case (st_reg)
      tar_pkg::S_IDLE: begin
        if (preq_reg) begin
          preq_next = 1'b0;
          st_next   = tar_pkg::S_POLL;
        end else if (start) begin
          areq_next  = 1'b0;
          dpend_next = 1'b0;
          att_next   = 4'h0;
          pass_flag_next = 1'b0;
          fail_flag_next = 1'b0;
          st_next    = tar_pkg::S_RST;
        end
      end
      tar_pkg::S_RST: if (mop_done) begin
        if (mop_presence) begin
          st_next = tar_pkg::S_SKIP;
        end else begin
          pass_next = 1'b0;
          fail_next = 1'b0;
          st_next   = tar_pkg::S_IDLE;
        end
      end
      tar_pkg::S_SKIP: if (mop_done) st_next = tar_pkg::S_WCMD;
      tar_pkg::S_WCMD: if (mop_done) begin
        byte_next = 5'h00;
        st_next   = tar_pkg::S_CHALLENGE_TRIGGER_IN;
      end
      tar_pkg::S_CHALLENGE_TRIGGER_IN: if (mop_done) begin
        byte_next = byte_reg + 5'h01;
        if (byte_reg == tar_pkg::CHALLENGE_TRIGGER_IN_LAST) st_next = tar_pkg::S_MCMD;
      end
      tar_pkg::S_MCMD: if (mop_done) st_next = tar_pkg::S_ZERO;
      tar_pkg::S_ZERO: if (mop_done) begin
        bit_next  = 8'h00;
        mism_next = 1'b0;
        st_next   = tar_pkg::S_READ;
      end
      tar_pkg::S_READ: if (mop_done) begin
        mism_next = mism_reg | bit_bad;
        bit_next  = bit_reg + 8'h01;
        if (bit_reg == tar_pkg::MAC_LAST) st_next = tar_pkg::S_FRST;
      end
      tar_pkg::S_FRST: if (mop_done) begin
        st_next = tar_pkg::S_IDLE;
        if (!mop_presence) begin
          pass_next = 1'b0;
          fail_next = 1'b0;
        end else if (!mism_reg) begin
          pass_next  = 1'b1;
          fail_next  = 1'b0;
          pass_flag_next = 1'b1;
          fail_flag_next = 1'b0;
        end else if (att_reg != last_attempt(auth_config_word[1:0])) begin
          att_next = att_reg + 4'h1;
          st_next  = tar_pkg::S_RST;
        end else begin
          pass_next  = 1'b0;
          fail_next  = 1'b1;
          pass_flag_next = 1'b0;
          fail_flag_next = 1'b1;
        end
      end
      tar_pkg::S_POLL: if (mop_done) begin
        st_next = tar_pkg::S_IDLE;
        if (!mop_presence) begin
          pass_next  = 1'b0;
          fail_next  = 1'b0;
          pass_flag_next = 1'b0;
          fail_flag_next = 1'b0;
        end
      end
      default: st_next = tar_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg    <= tar_pkg::S_IDLE;
      att_reg   <= 4'h0;
      byte_reg  <= 5'h00;
      bit_reg   <= 8'h00;
      mism_reg  <= 1'b0;
      pass_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      pass_flag_reg <= 1'b0;
      fail_flag_reg <= 1'b0;
      qcnt_reg  <= 22'h00_0000;
      blink_reg <= 1'b0;
      acnt_reg  <= 7'h00;
      pcnt_reg  <= 7'h00;
      areq_reg  <= 1'b0;
      preq_reg  <= 1'b0;
      dcnt_reg  <= 17'h0_0000;
      dpend_reg <= 1'b0;
      tprev_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      att_reg   <= att_next;
      byte_reg  <= byte_next;
      bit_reg   <= bit_next;
      mism_reg  <= mism_next;
      pass_reg  <= pass_next;
      fail_reg  <= fail_next;
      pass_flag_reg <= pass_flag_next;
      fail_flag_reg <= fail_flag_next;
      qcnt_reg  <= qcnt_next;
      blink_reg <= blink_next;
      acnt_reg  <= acnt_next;
      pcnt_reg  <= pcnt_next;
      areq_reg  <= areq_next;
      preq_reg  <= preq_next;
      dcnt_reg  <= dcnt_next;
      dpend_reg <= dpend_next;
      tprev_reg <= tprev_next;
    end
  end

  // Open drain: only ever pull low
  assign pass_line_out = 1'b0;
  assign fail_line_out = 1'b0;
  assign pass_line_oe  = pass_reg;
  assign fail_line_oe  = fail_reg &&
                         (!auth_config_word[tar_pkg::CFG_STYLE_BIT] || blink_reg);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence seq_mac_last;
    st_reg == tar_pkg::S_READ && mop_done && bit_reg == tar_pkg::MAC_LAST;
  endsequence
  a_mac_to_final: assert property (seq_mac_last |=> st_reg == tar_pkg::S_FRST)
    else $error("MAC read did not end after 160 bits");
  a_bit_mismatch: assert property (st_reg == tar_pkg::S_READ && mop_done && bit_bad
                                   |=> mism_reg)
    else $error("Mismatched bit not recorded");
  a_zero_then_read: assert property (st_reg == tar_pkg::S_ZERO && mop_done
                                     |=> st_reg == tar_pkg::S_READ && bit_reg == 8'h00)
    else $error("Read did not follow write-zero slots");
  a_skip_code: assert property (st_reg == tar_pkg::S_RST && mop_done && mop_presence
                                |=> mop.data == tar_pkg::CMD_SKIP && st_reg == tar_pkg::S_SKIP)
    else $error("Wrong addressing command");
  a_retry_again: assert property (st_reg == tar_pkg::S_FRST && mop_done && mop_presence
                                  && mism_reg && att_reg != last_attempt(auth_config_word[1:0])
                                  && (trig_act || !tprev_reg)
                                  |=> st_reg == tar_pkg::S_RST && $stable(fail_reg))
    else $error("Retry not started or outputs changed");
  a_pass_excl: assert property (pass_reg |-> pass_line_oe && !fail_line_oe)
    else $error("Pass indication wrong");
  a_poll_absent: assert property (st_reg == tar_pkg::S_POLL && mop_done && !mop_presence
                                  |=> !pass_reg && !fail_reg && !pass_flag_reg && !fail_flag_reg)
    else $error("Poll absence did not clear status");
  a_lock_cause: assert property ($rose(lock_reg) |-> $past(prog_copy))
    else $error("Lock set without copy");
  a_flags_start: assert property (start && !preq_reg |=> !pass_flag_reg && !fail_flag_reg)
    else $error("Flags not cleared at start");

endmodule // tar_auth_ctrl

/* tar_token_model.sv */
`timescale 1ns/10ps
module tar_token_model (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire tar_pkg::tar_mop_s mop,
  input  wire logic              mop_valid,
  input  wire logic              mop_strong_pullup,
  input  wire logic              present,
  input  wire logic              slow,
  input  wire logic [159:0]      mac,
  input  wire logic              flip_en,
  input  wire logic [7:0]        flip_idx,
  output logic                   mop_done,
  output logic                   mop_presence,
  output logic                   mop_bit,
  output logic [7:0]             n_att,
  output logic                   seq_err
);
  logic [2:0] cnt;
  logic [7:0] idx;
  logic       after_rst;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {mop_done, mop_presence, mop_bit, seq_err, after_rst} <= 5'h00;
      {cnt, idx, n_att} <= 19'h0_0000;
    end else begin
      mop_done     <= 1'b0;
      // Released line: toggles so a stale value never looks valid
      mop_presence <= ~mop_presence;
      mop_bit      <= ~mop_bit;
      if (mop_valid && !mop_done) begin
        if (cnt != (slow ? 3'h6 : 3'h1)) begin
          cnt <= cnt + 3'h1;
        end else begin
          cnt      <= 3'h0;
          mop_done <= 1'b1;
          case (mop.kind)
            tar_pkg::TAR_OP_RESET: begin
              mop_presence <= present;
              if (idx != 8'h00 && idx != 8'hA0) seq_err <= 1'b1;
              idx          <= 8'h00;
              after_rst    <= 1'b1;
            end
            tar_pkg::TAR_OP_WRITE: begin
              if (after_rst && mop.data != tar_pkg::CMD_SKIP) seq_err <= 1'b1;
              after_rst <= 1'b0;
            end
            tar_pkg::TAR_OP_ZERO8: begin
              if (!mop_strong_pullup) seq_err <= 1'b1;
              n_att <= n_att + 8'h01;
            end
            default: begin
              // Absent token leaves the pulled-up line high
              mop_bit <= present ? (mac[idx] ^ (flip_en && idx == flip_idx)) : 1'b1;
              if (idx > 8'h9F) seq_err <= 1'b1;
              idx <= idx + 8'h01;
            end
          endcase
        end
      end
    end
  end
endmodule // tar_token_model

/* tar_auth_ctrl_tb_top.sv */
`timescale 1ns/10ps
module tar_auth_ctrl_tb_top;
  logic              ref_clk, reset_n, trig, async_p, wr_en, copy, present, slow, flip_en;
  logic [7:0]        addr, wdata, rd, rdata, flip_idx, n_att, base;
  tar_pkg::tar_mop_s mop;
  logic              mop_valid, spu, done, pres, mbit, od, p_out, p_oe, f_out, f_oe, seq_err;
  logic [159:0]      mac;
  int                fails, n_checks, cyc, c, k, highs;

  always #50 ref_clk = ~ref_clk;

  tar_auth_ctrl #(.QUARTER_CYCLES(20), .TRIG_CYCLES(5)) tar_auth_ctrl_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .challenge_trigger_in(trig), .mop(mop),
    .mop_valid(mop_valid), .mop_strong_pullup(spu), .mop_done(done), .mop_presence(pres),
    .mop_bit(mbit), .async_presence_in(async_p), .overdrive_sel(od), .pass_line_out(p_out),
    .pass_line_oe(p_oe), .fail_line_out(f_out), .fail_line_oe(f_oe), .prog_wr_en(wr_en),
    .prog_addr(addr), .prog_wr_data(wdata), .prog_copy(copy), .prog_rd_data(rdata));

  tar_token_model tar_token_model_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .mop(mop), .mop_valid(mop_valid),
    .mop_strong_pullup(spu), .present(present), .slow(slow), .mac(mac), .flip_en(flip_en),
    .flip_idx(flip_idx), .mop_done(done), .mop_presence(pres), .mop_bit(mbit),
    .n_att(n_att), .seq_err(seq_err));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 rd = rdata;
  endtask

  task automatic nv_copy();
    @(posedge ref_clk);
    copy <= 1'b1;
    @(posedge ref_clk);
    copy <= 1'b0;
  endtask

  // Waits for the attempt count and an idle controller
  task automatic wait_att(input logic [7:0] n);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge ref_clk);
      if (n_att === n && mop_valid === 1'b0) break;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic set_trig(input logic v);
    @(posedge ref_clk);
    trig <= v;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    {ref_clk, reset_n, async_p, wr_en, copy, slow, flip_en} = 7'h00;
    {trig, present} = 2'h3;
    {addr, wdata, flip_idx} = 24'h00_0000;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    // No all-zero or all-one bytes, so an open bus never matches
    for (k = 0; k < 20; k++) mac[k*8 +: 8] = 8'h96 + 8'(k);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk(16'({p_oe, f_oe}), 16'h0000);
    rd8(8'h1C);
    chk(16'(rd), 16'h0000);
    rd8(8'h1D);
    chk(16'(rd), 16'h0000);
    rd8(8'h1E);
    chk(16'(rd), 16'h00FF);
    for (k = 0; k < 8; k++) wr(8'(k), 8'h3C + 8'(k));
    for (k = 0; k < 20; k++) wr(8'h08 + 8'(k), mac[k*8 +: 8]);
    set_trig(1'b0);
    wait_att(8'h01);
    chk(16'({p_oe, f_oe}), 16'h0002);
    chk(16'({p_out, f_out}), 16'h0000);
    chk(16'(seq_err), 16'h0000);
    rd8(8'h1D);
    chk(16'(rd[7:5]), 16'h0002);
    @(posedge ref_clk);
    async_p <= 1'b1;
    @(posedge ref_clk);
    async_p <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(16'(mop_valid), 16'h0000);
    set_trig(1'b1);
    repeat (2) @(posedge ref_clk);
    chk(16'(p_oe), 16'h0000);
    // Last bit corrupted: only the final compare can fail
    flip_en  <= 1'b1;
    flip_idx <= 8'd159;
    for (c = 0; c < 4; c++) begin
      slow <= c[1];
      wr(8'h1C, 8'(c));
      base = n_att;
      set_trig(1'b0);
      wait_att(base + (8'h01 << c));
      chk(16'(n_att - base), 16'h0001 << c);
      chk(16'({p_oe, f_oe}), 16'h0001);
      set_trig(1'b1);
      repeat (2) @(posedge ref_clk);
      chk(16'(f_oe), 16'h0000);
    end
    slow <= 1'b0;
    wr(8'h1C, 8'h41);
    base = n_att;
    set_trig(1'b0);
    wait_att(base + 8'h02);
    chk(16'(f_oe), 16'h0001);
    flip_en <= 1'b0;
    base = n_att;
    @(posedge ref_clk);
    async_p <= 1'b1;
    @(posedge ref_clk);
    async_p <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(16'({mop_valid, f_oe}), 16'h0003);
    rd8(8'h1D);
    chk(16'(rd[7:5]), 16'h0000);
    wait_att(base + 8'h01);
    chk(16'({p_oe, f_oe}), 16'h0002);
    wr(8'h1C, 8'h10);
    repeat (50) @(posedge ref_clk);
    chk(16'(p_oe), 16'h0001);
    present <= 1'b0;
    repeat (50) @(posedge ref_clk);
    chk(16'({p_oe, f_oe}), 16'h0000);
    rd8(8'h1D);
    chk(16'(rd[7:5]), 16'h0000);
    present <= 1'b1;
    wr(8'h1C, 8'h04);
    base = n_att;
    wait_att(base + 8'h01);
    chk(16'({p_oe, f_oe}), 16'h0002);
    present <= 1'b0;
    repeat (700) @(posedge ref_clk);
    chk(16'({p_oe, f_oe}), 16'h0000);
    // Periodic off; let a pending request drain before the token returns
    wr(8'h1C, 8'h00);
    repeat (100) @(posedge ref_clk);
    present <= 1'b1;
    wr(8'h1D, 8'h03);
    @(posedge ref_clk);
    chk(16'(od), 16'h0001);
    flip_en <= 1'b1;
    wr(8'h1C, 8'h80);
    base = n_att;
    set_trig(1'b1);
    wait_att(base + 8'h01);
    chk(16'(p_oe), 16'h0000);
    chk(16'(n_att - base), 16'h0001);
    highs = 0;
    for (k = 0; k < 80; k++) begin
      @(posedge ref_clk);
      highs += int'(f_oe === 1'b1);
    end
    chk(16'(highs), 16'h0028);
    set_trig(1'b0);
    repeat (2) @(posedge ref_clk);
    chk(16'(f_oe), 16'h0000);
    wr(8'h1D, 8'h04);
    nv_copy();
    rd8(8'h1D);
    chk(16'(rd[7]), 16'h0000);
    wr(8'h1D, 8'h08);
    nv_copy();
    rd8(8'h1D);
    chk(16'(rd[7]), 16'h0001);
    wr(8'h00, 8'h00);
    rd8(8'h00);
    chk(16'(rd), 16'h003C);
    chk(16'(seq_err), 16'h0000);
    tally_and_finish();
  end
endmodule // tar_auth_ctrl_tb_top
